// ### three_wire_config_port_test.sv
// self-checking bench: host and device joined by the link
`timescale 1ns/10ps
`default_nettype none
module three_wire_config_port_test;
   logic clk, reset, req_valid, req_write, req_ready, rsp_valid, cfg_upd_o;
   logic [6:0] req_addr, cfg_upd_addr_o;
   logic [7:0] req_wdata, rsp_rdata;
   logic [twc_pkg::NUM_REGS-1:0][7:0] cfg_o;
   logic [7:0] model [twc_pkg::NUM_REGS];
   logic [31:0] seed;
   logic [15:0] mon_sh;
   logic mon_pclk, mon_oe;
   int bad_count, check_count, mon_n, upd_n;
   twc_link_if link ();
   twc_host twc_host_i (.clk(clk), .reset(reset), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata));
   twc_device #(.N_REGS(twc_pkg::NUM_REGS)) twc_device_i (.clk(clk),
      .reset(reset), .link(link), .cfg_o(cfg_o), .cfg_upd_o(cfg_upd_o),
      .cfg_upd_addr_o(cfg_upd_addr_o));
   twc_link_checker twc_link_checker_i (.clk(clk), .reset(reset),
      .prog_clk(link.prog_clk), .strobe_o(link.strobe_o),
      .strobe_oe(link.strobe_oe), .host_sd_o(link.host_sd_o),
      .host_sd_oe(link.host_sd_oe), .dev_sd_o(link.dev_sd_o),
      .dev_sd_oe(link.dev_sd_oe),
      .address_phase_strobe(link.address_phase_strobe),
      .prog_serial_io(link.prog_serial_io));
   // ------------
   // helpers
   // ------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_rd(input logic [6:0] a);
      if (a < 7'(twc_pkg::NUM_REGS))
         return model[a];
      return twc_pkg::UNMAPPED_VALUE;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // wire monitor: bits captured at each falling link clock
   always @(posedge clk) begin
      if (link.strobe_oe && !mon_oe)
         mon_n = 0;
      if (mon_pclk && !link.prog_clk && link.strobe_oe) begin
         mon_sh = {mon_sh[14:0], link.prog_serial_io};
         mon_n++;
      end
      if (cfg_upd_o === 1'h1)
         upd_n++;
      mon_pclk = link.prog_clk;
      mon_oe = link.strobe_oe;
   end
   // one frame through the host request port, checked end to end
   task automatic xfer(input logic wr, input logic [6:0] a,
                       input logic [7:0] d);
      int n;
      int u0;
      logic ok;
      ok = a < 7'(twc_pkg::NUM_REGS);
      u0 = upd_n;
      @(posedge clk);
      req_valid <= 1'h1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'h1 && n < 200);
      req_valid <= 1'h0;
      repeat (60) @(posedge clk);
      if (ok && wr)
         check(16'(cfg_o[a]), 16'(model[a]));
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'h1 && n < 100);
      check(16'(n < 100), 16'h0001);
      check(16'(mon_n), 16'h0010);
      check(16'(mon_sh[15:8]), 16'({a, wr}));
      if (!wr) begin
         check(16'(rsp_rdata), 16'(exp_rd(a)));
         check(16'(mon_sh[7:0]), 16'(exp_rd(a)));
      end else begin
         check(16'(mon_sh[7:0]), 16'(d));
         repeat (6) @(posedge clk);
         if (ok)
            model[a] = d;
         if (ok)
            check(16'(cfg_o[a]), 16'(d));
         check(16'(cfg_upd_addr_o), 16'(a));
         check(16'(upd_n), 16'(u0 + 1));
      end
   endtask
   task automatic cmp_store();
      for (int i = 0; i < twc_pkg::NUM_REGS; i++)
         check(16'(cfg_o[i]), 16'(model[i]));
   endtask
   // ------------
   // sequence
   // ------------
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      reset = 1'h1;
      {req_valid, req_write, req_addr, req_wdata} = '0;
      {mon_pclk, mon_oe, mon_sh, mon_n, upd_n} = '0;
      seed = 32'ha533_df2c;
      foreach (model[i])
         model[i] = twc_pkg::REG_RESET;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      for (int i = 0; i < 30; i++)
         xfer(1'h0, (i == 29) ? 7'h7f : 7'(i), 8'h00);
      $display("test reset_read done");
      for (int i = 21; i >= 0; i--) begin
         seed = lfsr(seed);
         xfer(1'h1, 7'(i), seed[7:0]);
      end
      $display("test full_config done");
      xfer(1'h1, 7'h1b, 8'hff);
      xfer(1'h1, 7'h00, 8'h00);
      xfer(1'h1, 7'h1c, 8'h5a);
      xfer(1'h0, 7'h1b, 8'h00);
      xfer(1'h0, 7'h1c, 8'h00);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         xfer(seed[16], (seed[7:5] == 3'h0) ? 7'h7f : 7'(seed[4:0]),
              seed[15:8]);
      end
      $display("test random_mix done");
      repeat (400) @(posedge clk);
      cmp_store();
      for (int i = 0; i < twc_pkg::NUM_REGS; i++)
         xfer(1'h0, 7'(i), 8'h00);
      $display("test retain_readback done");
      @(posedge clk);
      reset <= 1'h1;
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      foreach (model[i])
         model[i] = twc_pkg::REG_RESET;
      @(posedge clk);
      cmp_store();
      xfer(1'h1, 7'h05, 8'ha5);
      xfer(1'h0, 7'h05, 8'h00);
      $display("test second_reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ### twc_device.sv
// configured-device end: serial frame decoder and configuration store
//
// Operation
// - 28 eight-bit registers, seven-bit frame address
// - frame is address, select bit, data
// - address goes most significant bit first
// - select high writes, low reads back
// - host holds strobe low through header
// - data bits captured on falling clock edge
// - register updated only after bit zero
// - contents survive power-down, lost at reset
// - writes accepted in any address order
// - read frame drives addressed register out
// - host releases data line during read-back
// - full setup 22 writes, power-down one
// - clock and data ignored in idle until strobe falls
// - undriven strobe reads inactive high
`timescale 1ns/10ps
`default_nettype none
module twc_device #(
   parameter int N_REGS = twc_pkg::NUM_REGS
) (
   input wire logic clk, // system clock
   input wire logic reset, // synchronous, active high
   twc_link_if.dev link, // three-wire link
   output logic [N_REGS-1:0][7:0] cfg_o, // configuration registers
   output logic cfg_upd_o, // one-cycle pulse per register write
   output logic [6:0] cfg_upd_addr_o // address of last write
);
   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   // the store index takes clog2(N_REGS+1) address bits, seven at most
   if (N_REGS < 1 || N_REGS > 127) begin : g_bad_regs
      $error("twc_device: N_REGS must lie in 1..127");
   end

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic lrst_s1_q;
   logic lrst_s2_q;
   twc_pkg::twc_dev_state_t st_q;
   twc_pkg::twc_dev_state_t st_d;
   logic [twc_pkg::BIT_CNT_W-1:0] cnt_q;
   logic [twc_pkg::BIT_CNT_W-1:0] cnt_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [6:0] addr_q;
   logic [6:0] addr_d;
   logic wr_q;
   logic wr_d;
   logic [6:0] wa_q;
   logic [6:0] wa_d;
   logic [7:0] wd_q;
   logic [7:0] wd_d;
   logic tgl_q;
   logic tgl_d;
   logic sd_out_q;
   logic sd_out_d;
   logic sd_oe_q;
   logic sd_oe_d;
   logic [7:0] rd_word;
   logic sdi;
   logic strobe;
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;
   logic [N_REGS-1:0][7:0] regs_q;
   logic [N_REGS-1:0][7:0] regs_d;
   logic upd_q;
   logic upd_d;
   logic [6:0] upd_addr_q;
   logic [6:0] upd_addr_d;
   logic rise_q;
   logic rise_s1_q;
   logic rise_s2_q;
   logic live_q;
   logic live_d;

   assign sdi = link.prog_serial_io;
   // strobe already reads high when undriven
   assign strobe = link.address_phase_strobe;

   // ------------------------------------------------------------------
   // link-domain reset
   // ------------------------------------------------------------------
   // reset level carried onto the falling link edge by two flops
   always_ff @(negedge link.prog_clk) begin
      lrst_s1_q <= reset;
      lrst_s2_q <= lrst_s1_q;
   end

   // ------------------------------------------------------------------
   // frame decoder, falling link edge
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      wr_d = wr_q;
      wa_d = wa_q;
      wd_d = wd_q;
      tgl_d = 1'h0;
      if (lrst_s2_q) begin
         st_d = twc_pkg::DEV_IDLE;
         cnt_d = '0;
      end else begin
         case (st_q)
            twc_pkg::DEV_ADDR: begin
               if (!strobe) begin
                  // msb first, so shifting left lands a6 on top
                  sh_d = {sh_q[6:0], sdi};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'(twc_pkg::HDR_BITS - 1)) begin
                     addr_d = sh_q[6:0];
                     wr_d = (sdi == twc_pkg::WR_SEL);
                     st_d = twc_pkg::DEV_DATA;
                  end
               end else begin
                  // header broken off: drop it and go quiet
                  st_d = twc_pkg::DEV_IDLE;
                  cnt_d = '0;
               end
            end
            twc_pkg::DEV_DATA: begin
               if (!strobe) begin
                  // fresh strobe fall: this bit opens a new frame
                  st_d = twc_pkg::DEV_ADDR;
                  cnt_d = 4'h1;
                  sh_d = {sh_q[6:0], sdi};
               end else begin
                  sh_d = {sh_q[6:0], sdi};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'(twc_pkg::FRAME_BITS - 1)) begin
                     st_d = twc_pkg::DEV_IDLE;
                     cnt_d = '0;
                     if (wr_q) begin
                        // word handed over only once bit zero is in
                        wa_d = addr_q;
                        wd_d = {sh_q[6:0], sdi};
                        tgl_d = 1'h1;
                     end
                  end
               end
            end
            default: begin
               // idle: clock and data mean nothing until strobe falls
               if (!strobe) begin
                  st_d = twc_pkg::DEV_ADDR;
                  cnt_d = 4'h1;
                  sh_d = {sh_q[6:0], sdi};
               end else begin
                  st_d = twc_pkg::DEV_IDLE;
                  cnt_d = '0;
               end
            end
         endcase
      end
   end

   always_ff @(negedge link.prog_clk) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      tgl_q <= tgl_d;
   end

   // ------------------------------------------------------------------
   // read-back driver, rising link edge
   // ------------------------------------------------------------------
   // the store only changes a few system clocks after a write frame
   // ends, so it is steady through any later read frame
   always_comb begin
      rd_word = twc_pkg::UNMAPPED_VALUE;
      if (twc_pkg::twc_addr_ok(addr_q, N_REGS)) begin
         rd_word = regs_q[addr_q[$clog2(N_REGS+1)-1:0]];
      end
   end

   always_comb begin
      sd_oe_d = 1'h0;
      sd_out_d = 1'h1;
      if (!lrst_s2_q && st_q == twc_pkg::DEV_DATA && !wr_q) begin
         sd_oe_d = 1'h1;
         // next bit index 8..15 maps to d7..d0
         sd_out_d = rd_word[~cnt_q[2:0]];
      end
   end

   always_ff @(posedge link.prog_clk) begin
      sd_oe_q <= sd_oe_d;
      sd_out_q <= sd_out_d;
      rise_q <= 1'h1;
   end

   assign link.dev_sd_o = sd_out_q;
   // link flops hold nothing until the first rising link edge, so the
   // driver is kept off until that edge has been seen
   assign link.dev_sd_oe = sd_oe_q & live_q;

   // ------------------------------------------------------------------
   // write crossing into system clock
   // ------------------------------------------------------------------
   // write level stands from bit zero until the next frame's first bit,
   // as the link clock stops between frames; needs no link reset
   always_ff @(posedge clk) begin
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      rise_s1_q <= rise_q;
      rise_s2_q <= rise_s1_q;
   end

   // ------------------------------------------------------------------
   // configuration store
   // ------------------------------------------------------------------
   // only reset clears it; power-down has no path in here
   always_comb begin
      regs_d = regs_q;
      upd_d = 1'h0;
      upd_addr_d = upd_addr_q;
      live_d = live_q;
      if (rise_s2_q) begin
         live_d = 1'h1;
      end
      if (reset) begin
         live_d = 1'h0;
         for (int i = 0; i < N_REGS; i++) begin
            regs_d[i] = twc_pkg::REG_RESET;
         end
         upd_addr_d = '0;
      end else if (tgl_s2_q && !tgl_s3_q) begin
         upd_d = 1'h1;
         upd_addr_d = wa_q;
         // any address, any order; out-of-range writes are dropped
         if (twc_pkg::twc_addr_ok(wa_q, N_REGS)) begin
            regs_d[wa_q[$clog2(N_REGS+1)-1:0]] = wd_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      regs_q <= regs_d;
      live_q <= live_d;
      upd_q <= upd_d;
      upd_addr_q <= upd_addr_d;
   end

   assign cfg_o = regs_q;
   assign cfg_upd_o = upd_q;
   assign cfg_upd_addr_o = upd_addr_q;
endmodule
`default_nettype wire

// ### twc_host.sv
// host end: drives three-wire frames from a request port
`timescale 1ns/10ps
`default_nettype none
module twc_host (
   input wire logic clk, // system clock
   input wire logic reset, // synchronous, active high
   twc_link_if.host link, // three-wire link
   input wire logic req_valid, // frame request
   output logic req_ready, // idle, request taken
   input wire logic req_write, // 1 write, 0 read
   input wire logic [6:0] req_addr, // register address
   input wire logic [7:0] req_wdata, // write value
   output logic rsp_valid, // one-cycle pulse at frame end
   output logic [7:0] rsp_rdata // read-back value
);
   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   if (twc_pkg::HIGH_CYC > 4 || twc_pkg::LOW_CYC > 4) begin : g_bad
      $error("twc_host: phase counts exceed counter width");
   end

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   twc_pkg::twc_host_state_t st_q;
   twc_pkg::twc_host_state_t st_d;
   logic [twc_pkg::PH_W-1:0] ph_q;
   logic [twc_pkg::PH_W-1:0] ph_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [15:0] sh_q;
   logic [15:0] sh_d;
   logic wr_q;
   logic wr_d;
   logic pclk_q;
   logic pclk_d;
   logic address_phase_strobe_q;
   logic address_phase_strobe_d;
   logic address_phase_strobe_oe_q;
   logic address_phase_strobe_oe_d;
   logic sdo_q;
   logic sdo_d;
   logic sdoe_q;
   logic sdoe_d;
   logic [7:0] rd_q;
   logic [7:0] rd_d;
   logic rsp_q;
   logic rsp_d;
   logic sdi_s1_q;
   logic sdi_s2_q;

   // ------------------------------------------------------------------
   // data line synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      sdi_s1_q <= link.prog_serial_io;
      sdi_s2_q <= sdi_s1_q;
   end

   // ------------------------------------------------------------------
   // frame sequencer
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      wr_d = wr_q;
      pclk_d = pclk_q;
      address_phase_strobe_d = address_phase_strobe_q;
      address_phase_strobe_oe_d = address_phase_strobe_oe_q;
      sdo_d = sdo_q;
      sdoe_d = sdoe_q;
      rd_d = rd_q;
      rsp_d = 1'h0;
      if (reset) begin
         st_d = twc_pkg::HST_IDLE;
         pclk_d = 1'h1;
         address_phase_strobe_d = 1'h1;
         address_phase_strobe_oe_d = 1'h0;
         sdoe_d = 1'h0;
         sdo_d = 1'h1;
      end else begin
         case (st_q)
            twc_pkg::HST_HIGH: begin
               ph_d = ph_q + 2'h1;
               // strobe rises one cycle after the clock rise
               if (ph_q == '0 && bit_q >= 4'(twc_pkg::HDR_BITS)) begin
                  address_phase_strobe_d = 1'h1;
               end
               if (ph_q == 2'(twc_pkg::HIGH_CYC - 1)) begin
                  ph_d = '0;
                  pclk_d = 1'h0;
                  st_d = twc_pkg::HST_LOW;
               end
            end
            twc_pkg::HST_LOW: begin
               ph_d = ph_q + 2'h1;
               if (ph_q == '0) begin
                  if (!wr_q && bit_q >= 4'(twc_pkg::HDR_BITS)) begin
                     rd_d = {rd_q[6:0], sdi_s2_q};
                  end
                  sh_d = {sh_q[14:0], 1'h0};
                  sdo_d = sh_q[14];
                  // let go of the line before read-back data
                  sdoe_d = wr_q ||
                     bit_q < 4'(twc_pkg::HDR_BITS - 1);
               end
               if (ph_q == 2'(twc_pkg::LOW_CYC - 1)) begin
                  ph_d = '0;
                  pclk_d = 1'h1;
                  if (bit_q == 4'(twc_pkg::FRAME_BITS - 1)) begin
                     st_d = twc_pkg::HST_DONE;
                  end else begin
                     bit_d = bit_q + 4'h1;
                     st_d = twc_pkg::HST_HIGH;
                  end
               end
            end
            twc_pkg::HST_DONE: begin
               rsp_d = 1'h1;
               sdoe_d = 1'h0;
               address_phase_strobe_oe_d = 1'h0;
               st_d = twc_pkg::HST_IDLE;
            end
            default: begin
               pclk_d = 1'h1;
               if (req_valid) begin
                  // any number of frames; 22 for a full setup
                  sh_d = {req_addr, req_write, req_wdata};
                  wr_d = req_write;
                  sdo_d = req_addr[6];
                  sdoe_d = 1'h1;
                  address_phase_strobe_d = 1'h0;
                  address_phase_strobe_oe_d = 1'h1;
                  bit_d = '0;
                  ph_d = '0;
                  st_d = twc_pkg::HST_HIGH;
               end else begin
                  st_d = twc_pkg::HST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      wr_q <= wr_d;
      pclk_q <= pclk_d;
      address_phase_strobe_q <= address_phase_strobe_d;
      address_phase_strobe_oe_q <= address_phase_strobe_oe_d;
      sdo_q <= sdo_d;
      sdoe_q <= sdoe_d;
      rd_q <= rd_d;
      rsp_q <= rsp_d;
   end

   assign req_ready = (st_q == twc_pkg::HST_IDLE) && !reset;
   assign rsp_valid = rsp_q;
   assign rsp_rdata = rd_q;
   assign link.prog_clk = pclk_q;
   assign link.strobe_o = address_phase_strobe_q;
   assign link.strobe_oe = address_phase_strobe_oe_q;
   assign link.host_sd_o = sdo_q;
   assign link.host_sd_oe = sdoe_q;
endmodule
`default_nettype wire

// ### twc_link_checker.sv
// assertions on the three-wire link between host and device
`timescale 1ns/10ps
`default_nettype none
module twc_link_checker (
   input wire logic clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire logic prog_clk, // link clock
   input wire logic strobe_o, // host strobe value
   input wire logic strobe_oe, // host strobe enable
   input wire logic host_sd_o, // host data value
   input wire logic host_sd_oe, // host data enable
   input wire logic dev_sd_o, // device data value
   input wire logic dev_sd_oe, // device data enable
   input wire logic address_phase_strobe, // resolved strobe
   input wire logic prog_serial_io // resolved data line
);
   // ------------
   // frame tracking
   // ------------
   logic pclk_q, pclk_d, rw_q, rw_d, seen_q, seen_d, fall;
   logic [4:0] cnt_q, cnt_d;
   assign fall = pclk_q & ~prog_clk;
   always_comb begin
      pclk_d = prog_clk;
      cnt_d = strobe_oe ? cnt_q + 5'(fall) : 5'h00;
      rw_d = (fall && cnt_q == 5'h07) ? prog_serial_io : rw_q;
      seen_d = seen_q | (strobe_oe & strobe_o === 1'h0);
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         pclk_q <= 1'h1;
         cnt_q <= 5'h00;
         rw_q <= 1'h1;
         seen_q <= 1'h0;
      end else begin
         pclk_q <= pclk_d;
         cnt_q <= cnt_d;
         rw_q <= rw_d;
         seen_q <= seen_d;
      end
   end
   // ------------
   // link rules
   // ------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_header_low:
      assert property (fall && cnt_q < 5'h08 |-> !address_phase_strobe)
      else $error("strobe high during header bit");
   a_strobe_setup:
      assert property ($fell(address_phase_strobe) |-> prog_clk [*2])
      else $error("strobe fell too close to clock fall");
   a_data_high:
      assert property (fall && cnt_q >= 5'h08 |-> address_phase_strobe)
      else $error("strobe low during data bit");
   a_frame_len:
      assert property ($fell(strobe_oe) |-> cnt_q == 5'h10)
      else $error("frame did not carry sixteen bits");
   a_host_released:
      assert property (strobe_oe && cnt_q >= 5'h08 && !rw_q && prog_clk
                       |-> !host_sd_oe)
      else $error("host drives line during read-back");
   a_dev_drives:
      assert property (fall && cnt_q >= 5'h08 && !rw_q |-> dev_sd_oe)
      else $error("device not driving read bit");
   a_write_no_drive:
      assert property (strobe_oe && cnt_q >= 5'h08 && rw_q |-> !dev_sd_oe)
      else $error("device drives line on write frame");
   a_no_contention:
      assert property (!(host_sd_oe && dev_sd_oe))
      else $error("both ends drive the data line");
   a_bit_after_rise:
      assert property (dev_sd_oe && $changed(dev_sd_o) |-> prog_clk)
      else $error("read bit changed while clock low");
   a_idle_quiet:
      assert property (seen_q && !strobe_oe && !$past(strobe_oe)
                       |-> !dev_sd_oe)
      else $error("device drives line while idle");
   a_low_width:
      assert property (fall |=> !prog_clk)
      else $error("clock low phase too short");
   a_data_setup:
      assert property (fall && host_sd_oe |-> $stable(host_sd_o))
      else $error("host data moved at capture edge");
endmodule
`default_nettype wire

// ### twc_link_if.sv
// three-wire link between host and configured device
`timescale 1ns/10ps
`default_nettype none
interface twc_link_if;
   logic prog_clk;
   logic strobe_o;
   logic strobe_oe;
   logic host_sd_o;
   logic host_sd_oe;
   logic dev_sd_o;
   logic dev_sd_oe;
   logic address_phase_strobe;
   logic prog_serial_io;

   // internal pull-up keeps an undriven strobe inactive
   assign address_phase_strobe = strobe_oe ? strobe_o : 1'h1;
   // released line reads high (pull or open collector)
   assign prog_serial_io = host_sd_oe ? host_sd_o :
                           (dev_sd_oe ? dev_sd_o : 1'h1);

   modport dev(
      input prog_clk,
      input address_phase_strobe,
      input prog_serial_io,
      output dev_sd_o,
      output dev_sd_oe
   );

   modport host(
      output prog_clk,
      output strobe_o,
      output strobe_oe,
      output host_sd_o,
      output host_sd_oe,
      input prog_serial_io
   );
endinterface
`default_nettype wire

// ### twc_pkg.sv
// shared constants and types for the three-wire configuration link
`default_nettype none
package twc_pkg;
   // ------------------------------------------------------------------
   // frame layout
   // ------------------------------------------------------------------
   localparam int NUM_REGS = 28;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int HDR_BITS = 8;
   localparam int FRAME_BITS = 16;
   localparam int BIT_CNT_W = 4;
   localparam logic WR_SEL = 1'h1;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_CLK_LOW_NS = 50;
   localparam int T_CLK_HIGH_NS = 50;
   localparam int T_HOLD_NS = 10;
   localparam int LOW_CYC =
      (T_CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // high phase also covers the strobe hold after the rising edge
   localparam int HIGH_CYC =
      (T_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS +
      (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PH_W = 2;

   // ------------------------------------------------------------------
   // state types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_ADDR = 2'h1,
      DEV_DATA = 2'h3
   } twc_dev_state_t;

   typedef enum logic [1:0] {
      HST_IDLE = 2'h0,
      HST_HIGH = 2'h1,
      HST_LOW = 2'h3,
      HST_DONE = 2'h2
   } twc_host_state_t;

   function automatic logic twc_addr_ok(input logic [ADDR_W-1:0] a,
                                        input int n);
      return {25'h000_0000, a} < n;
   endfunction
endpackage
`default_nettype wire
